// *** design/analog_input_diag_record.sv ***
/*
 * Read-only diagnostic record of a two-channel analog input module.
 * A byte index selects a record byte; the answer is registered.
 * Assumes channel status inputs are synchronous levels from the
 * conversion path and reset is power-on.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: channel type byte holds 7-bit code
// R2: diagnostic bits per channel reads eight
// R3: channel count byte reads two
// R4: group error bits 0 and 1
// R5: channel error bit 0 parameter error
// R6: channel error bit 6 underflow
// R7: channel error bit 7 overflow
// R8: diagnostic event captures ticker into timestamp
// R9: ticker starts at zero on power-on
// R10: ticker wraps to zero after maximum
// R11: ticker counts once per microsecond
// R12: group bit set by channel errors
module analog_input_diag_record
	import diag_record_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_CH-1:0] param_err_in,
	input wire logic [NUM_CH-1:0] underflow_in,
	input wire logic [NUM_CH-1:0] overflow_in,
	input wire logic [4:0] rd_index_in,
	output logic [7:0] rd_data_out,
	output logic [7:0] first_channel_error_out,
	output logic [7:0] second_channel_error_out,
	output logic [7:0] channel_group_error_out,
	output logic [31:0] diag_timestamp_out,
	output logic diag_event_out
);
	logic [31:0] ticks;
	logic [7:0] ch_err [NUM_CH];
	logic [NUM_CH-1:0] ch_any;
	logic [NUM_CH-1:0] ch_new;

	logic [7:0] group_q;
	logic [7:0] group_d;
	logic [NUM_CH-1:0] any_q;
	logic [NUM_CH-1:0] any_d;
	logic [31:0] stamp_q;
	logic [31:0] stamp_d;
	logic event_q;
	logic event_d;
	logic [7:0] first_q;
	logic [7:0] second_q;
	logic [7:0] rd_q;
	logic [7:0] rd_d;
	logic [7:0] type_byte;

	us_ticker ticker_u (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.ticks_out(ticks)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			channel_error_byte err_u (
				.ref_clk_in(ref_clk_in),
				.sys_rst_in(sys_rst_in),
				.param_err_in(param_err_in[g]),
				.underflow_in(underflow_in[g]),
				.overflow_in(overflow_in[g]),
				.err_byte_out(ch_err[g])
			);
			assign ch_any[g] = |ch_err[g];
			// a diagnostic is the channel going from no error bit set to any error bit set
			assign ch_new[g] = ch_any[g] & ~any_q[g];
		end
	endgenerate

	assign type_byte = {1'b0, TYPE_ANALOG_IN}; // R1

	always_comb
	begin
		group_d = RESET_BYTE;
		group_d[NUM_CH-1:0] = ch_any; // R4 R12
		any_d = ch_any;
		event_d = |ch_new;
		stamp_d = stamp_q;
		if (|ch_new)
			stamp_d = ticks; // R8
	end

	// register bytes at their indices; reserved bytes read zero
	always_comb
	begin
		rd_d = RESET_BYTE;
		if (rd_index_in == IDX_CHANNEL_TYPE)
			rd_d = type_byte; // R1
		else if (rd_index_in == IDX_DIAG_BITS)
			rd_d = DIAG_BITS_VALUE; // R2
		else if (rd_index_in == IDX_CHANNEL_COUNT)
			rd_d = CHANNEL_COUNT_VALUE; // R3
		else if (rd_index_in == IDX_GROUP_ERROR)
			rd_d = group_q; // R4
		else if (rd_index_in == IDX_FIRST_CH_ERROR)
			rd_d = ch_err[0];
		else if (rd_index_in == IDX_SECOND_CH_ERROR)
			rd_d = ch_err[1];
		else if (rd_index_in == IDX_TIMESTAMP)
			rd_d = stamp_q[7:0];
		else if (rd_index_in == IDX_TIMESTAMP + 5'h1)
			rd_d = stamp_q[15:8];
		else if (rd_index_in == IDX_TIMESTAMP + 5'h2)
			rd_d = stamp_q[23:16];
		else if (rd_index_in == IDX_TIMESTAMP + 5'h3)
			rd_d = stamp_q[31:24];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			group_q <= RESET_BYTE;
			any_q <= '0;
			stamp_q <= RESET_TICKER;
			event_q <= 1'b0;
			first_q <= RESET_BYTE;
			second_q <= RESET_BYTE;
			rd_q <= RESET_BYTE;
		end
		else
		begin
			group_q <= group_d;
			any_q <= any_d;
			stamp_q <= stamp_d;
			event_q <= event_d;
			first_q <= ch_err[0];
			second_q <= ch_err[1];
			rd_q <= rd_d;
		end
	end

	assign rd_data_out = rd_q;
	assign first_channel_error_out = first_q;
	assign second_channel_error_out = second_q;
	assign channel_group_error_out = group_q;
	assign diag_timestamp_out = stamp_q;
	assign diag_event_out = event_q;
endmodule : analog_input_diag_record
`default_nettype wire

// *** design/channel_error_byte.sv ***
/*
 * One channel's specific error byte, refreshed every cycle from
 * that channel's status levels.
 * Assumes status inputs are synchronous levels.
 */
`timescale 1ns/1ns
`default_nettype none
module channel_error_byte
	import diag_record_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic param_err_in,
	input wire logic underflow_in,
	input wire logic overflow_in,
	output logic [7:0] err_byte_out
);
	logic [7:0] err_q;
	logic [7:0] err_d;

	always_comb
	begin
		err_d = RESET_BYTE;
		err_d[BIT_PARAM_ERR] = param_err_in; // R5
		err_d[BIT_UNDERFLOW] = underflow_in; // R6
		err_d[BIT_OVERFLOW] = overflow_in; // R7
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			err_q <= RESET_BYTE;
		else
			err_q <= err_d;
	end

	assign err_byte_out = err_q;
endmodule : channel_error_byte
`default_nettype wire

// *** design/diag_record_pkg.sv ***
/*
 * Constants for the analog input diagnostic record: record byte
 * indices, field positions, fixed codes and ticker timing.
 * Assumes a single 100 MHz system clock.
 */
`default_nettype none
package diag_record_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	localparam int NUM_CH = 2;
	localparam int UNUSED_CH = 6;

	// record byte indices
	localparam logic [4:0] IDX_CHANNEL_TYPE = 5'h06;
	localparam logic [4:0] IDX_DIAG_BITS = 5'h07;
	localparam logic [4:0] IDX_CHANNEL_COUNT = 5'h08;
	localparam logic [4:0] IDX_GROUP_ERROR = 5'h09;
	localparam logic [4:0] IDX_FIRST_CH_ERROR = 5'h0a;
	localparam logic [4:0] IDX_SECOND_CH_ERROR = 5'h0b;
	localparam logic [4:0] IDX_UNUSED_LOW = 5'h0c;
	localparam logic [4:0] IDX_UNUSED_HIGH = 5'h11;
	localparam logic [4:0] IDX_TIMESTAMP = 5'h13;

	typedef enum logic [6:0] {
		TYPE_DIGITAL_IN = 7'h70,
		TYPE_ANALOG_IN = 7'h71,
		TYPE_DIGITAL_OUT = 7'h72,
		TYPE_ANALOG_OUT = 7'h73,
		TYPE_ANALOG_INOUT = 7'h74,
		TYPE_COUNTER = 7'h76
	} channel_type_t;

	localparam logic [7:0] DIAG_BITS_VALUE = 8'h08;
	localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h02;

	localparam int BIT_PARAM_ERR = 0;
	localparam int BIT_UNDERFLOW = 6;
	localparam int BIT_OVERFLOW = 7;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_TICKER = 32'h0000_0000;
endpackage : diag_record_pkg
`default_nettype wire

// *** design/us_ticker.sv ***
/*
 * Free-running microsecond ticker: divides the system clock down
 * to one count per microsecond and wraps at the top of 32 bits.
 * Assumes the synchronous reset is the power-on reset.
 */
`timescale 1ns/1ns
`default_nettype none
module us_ticker
	import diag_record_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	output logic [31:0] ticks_out
);
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic [31:0] ticks_q;
	logic [31:0] ticks_d;

	always_comb
	begin
		div_d = div_q + DIV_W'(1);
		ticks_d = ticks_q;
		if (div_q == DIV_LAST)
		begin
			div_d = '0;
			ticks_d = ticks_q + 32'h1; // R11 R10
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			div_q <= '0;
			ticks_q <= RESET_TICKER; // R9
		end
		else
		begin
			div_q <= div_d;
			ticks_q <= ticks_d;
		end
	end

	assign ticks_out = ticks_q;
endmodule : us_ticker
`default_nettype wire

// *** test/analog_input_diag_record_bench.sv ***
/* self-checking bench for the diagnostic record
   assumes package, design, coupler model and checker compiled first */
`timescale 1ns/1ns
`default_nettype none
module analog_input_diag_record_bench;
	import diag_record_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [1:0] par = 2'h0, und = 2'h0, ovr = 2'h0;
	logic [4:0] req = 5'h00;
	logic [4:0] idx;
	logic [7:0] rd, e0, e1, grp, seen, x0, x1;
	logic [31:0] ts, exp_ts;
	logic ev;
	int miscompares = 0, checks_done = 0, cyc = 0, rel = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) cyc <= cyc + 1;
	analog_input_diag_record i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.param_err_in(par), .underflow_in(und), .overflow_in(ovr), .rd_index_in(idx),
		.rd_data_out(rd), .first_channel_error_out(e0), .second_channel_error_out(e1),
		.channel_group_error_out(grp), .diag_timestamp_out(ts), .diag_event_out(ev));
	coupler_model i_cpl (.ref_clk_in(ref_clk_in), .req_in(req), .rd_data_in(rd),
		.rd_index_out(idx), .data_out(seen));
	function automatic logic [7:0] eb(input logic p, input logic u, input logic o);
		return {o, u, 5'h00, p};
	endfunction : eb
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		if (got !== exp)
			miscompares++;
	endtask : check
	task automatic rd_chk(input logic [4:0] i, input logic [7:0] exp);
		@(posedge ref_clk_in);
		req <= i;
		repeat (3) @(posedge ref_clk_in);
		#1 check("record byte", {24'h0, exp}, {24'h0, seen});
	endtask : rd_chk
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	initial
	begin
		#200000;
		miscompares++;
		stop_test();
	end
	initial
	begin
		void'($urandom(75));
		repeat (20) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rel = cyc;
		rd_chk(IDX_CHANNEL_TYPE, 8'h71);
		rd_chk(IDX_DIAG_BITS, 8'h08);
		rd_chk(IDX_CHANNEL_COUNT, 8'h02);
		rd_chk(IDX_UNUSED_HIGH, 8'h00);
		rd_chk(IDX_UNUSED_LOW, 8'h00);
		repeat (1200) @(posedge ref_clk_in);
		par <= 2'h1;
		exp_ts = 32'(cyc - rel) / 32'd100;
		repeat (2) @(posedge ref_clk_in);
		#1 check("event", 32'h1, {31'h0, ev});
		check("timestamp", 32'h1, {31'h0, ts + 1 >= exp_ts && ts <= exp_ts + 1});
		@(posedge ref_clk_in);
		#1 check("event end", 32'h0, {31'h0, ev});
		rd_chk(IDX_TIMESTAMP, ts[7:0]);
		rd_chk(IDX_TIMESTAMP + 5'h1, ts[15:8]);
		rd_chk(IDX_TIMESTAMP + 5'h2, ts[23:16]);
		rd_chk(IDX_TIMESTAMP + 5'h3, ts[31:24]);
		for (int n = 0; n < 24; n++)
		begin
			@(posedge ref_clk_in);
			par <= n == 0 ? 2'h3 : 2'($urandom);
			und <= n == 0 ? 2'h3 : 2'($urandom);
			ovr <= n == 0 ? 2'h3 : 2'($urandom);
			repeat (3) @(posedge ref_clk_in);
			#1 check("first ch", {24'h0, eb(par[0], und[0], ovr[0])}, {24'h0, e0});
			x0 = eb(par[0], und[0], ovr[0]);
			x1 = eb(par[1], und[1], ovr[1]);
			check("second ch", {24'h0, x1}, {24'h0, e1});
			check("group", {30'h0, |x1, |x0}, {24'h0, grp});
			rd_chk(IDX_SECOND_CH_ERROR, x1);
			rd_chk(IDX_FIRST_CH_ERROR, x0);
			rd_chk(IDX_GROUP_ERROR, {6'h00, |x1, |x0});
		end
		stop_test();
	end
endmodule : analog_input_diag_record_bench
`default_nettype wire

// *** test/coupler_model.sv ***
/* bus coupler model: presents a record byte index, captures the answer
   assumes the record answers one edge after the index is sampled */
`timescale 1ns/1ns
`default_nettype none
module coupler_model (
	input wire logic ref_clk_in,
	input wire logic [4:0] req_in,
	input wire logic [7:0] rd_data_in,
	output logic [4:0] rd_index_out = 5'h00,
	output logic [7:0] data_out
);
	always_ff @(posedge ref_clk_in)
	begin
		rd_index_out <= req_in;
		data_out <= rd_data_in;
	end
endmodule : coupler_model
`default_nettype wire

// *** test/diag_record_assertions.sv ***
/* checker for the diagnostic record ports
   assumes it is bound to the record's top module */
`timescale 1ns/1ns
`default_nettype none
module diag_record_checker
	import diag_record_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [NUM_CH-1:0] param_err_in,
	input wire logic [NUM_CH-1:0] underflow_in,
	input wire logic [NUM_CH-1:0] overflow_in,
	input wire logic [4:0] rd_index_in,
	input wire logic [7:0] rd_data_out,
	input wire logic [7:0] first_channel_error_out,
	input wire logic [7:0] second_channel_error_out,
	input wire logic [7:0] channel_group_error_out,
	input wire logic [31:0] diag_timestamp_out,
	input wire logic diag_event_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_type; rd_index_in == IDX_CHANNEL_TYPE |=> rd_data_out == 8'h71; endproperty
	a_type: assert property (p_type) else $error("type byte");
	property p_bits; rd_index_in == IDX_DIAG_BITS |=> rd_data_out == 8'h08; endproperty
	a_bits: assert property (p_bits) else $error("bits byte");
	property p_cnt; rd_index_in == IDX_CHANNEL_COUNT |=> rd_data_out == 8'h02; endproperty
	a_cnt: assert property (p_cnt) else $error("count byte");
	property p_grp; channel_group_error_out ==
		{6'h00, |second_channel_error_out, |first_channel_error_out}; endproperty
	a_grp: assert property (p_grp) else $error("group byte");
	property p_par; !$past(sys_rst_in, 2) |->
		first_channel_error_out[0] == $past(param_err_in[0], 2); endproperty
	a_par: assert property (p_par) else $error("param bit");
	property p_und; !$past(sys_rst_in, 2) |->
		first_channel_error_out[6] == $past(underflow_in[0], 2); endproperty
	a_und: assert property (p_und) else $error("underflow bit");
	property p_ovr; !$past(sys_rst_in, 2) |->
		second_channel_error_out[7] == $past(overflow_in[1], 2); endproperty
	a_ovr: assert property (p_ovr) else $error("overflow bit");
	property p_ts; !diag_event_out |-> $stable(diag_timestamp_out); endproperty
	a_ts: assert property (p_ts) else $error("timestamp moved");
	c_ev: cover property (diag_event_out);
	c_grp: cover property (channel_group_error_out == 8'h03);
	c_type: cover property (rd_index_in == IDX_CHANNEL_TYPE);
endmodule : diag_record_checker
bind analog_input_diag_record diag_record_checker i_chk (.*);
`default_nettype wire
